// ==== hw/drc_compressor.sv ====
`timescale 1ns/100ps
// level and threshold are attenuation below full scale in whole dB (larger is quieter)
module drc_compressor
  import drc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_wr,
  input  wire logic [6:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  input  wire logic       i_word_clk,
  input  wire logic [7:0] i_level_db,
  output logic            o_enable,
  output logic      [7:0] o_threshold_db,
  output logic      [1:0] o_hysteresis_db,
  output logic            o_reduce
);
  logic [7:0]  reg_thr, next_reg_thr;
  logic [7:0]  reg_hold, next_reg_hold;
  logic [7:0]  rdata, next_rdata;
  drc_state_t  state, next_state;
  logic [17:0] hold_cnt, next_hold_cnt;
  logic [17:0] hold_len;
  logic [3:0]  hold_code;
  logic [7:0]  thr_db;
  logic [8:0]  rel_db;
  logic        over, under;

  // reserved bits are masked so they always read back their reset value
  always_comb begin
    next_reg_thr  = reg_thr;
    next_reg_hold = reg_hold;
    if (i_wr && i_addr == DRC_OFS_THRESHOLD) begin
      next_reg_thr = i_wdata & DRC_MASK_THRESHOLD;
    end
    if (i_wr && i_addr == DRC_OFS_HOLD) begin
      next_reg_hold = i_wdata & DRC_MASK_HOLD;
    end
    case (i_addr)
      DRC_OFS_THRESHOLD: next_rdata = reg_thr;
      DRC_OFS_HOLD:      next_rdata = reg_hold;
      default:           next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      reg_thr  <= DRC_RST_THRESHOLD;
      reg_hold <= DRC_RST_HOLD;
      rdata    <= 8'h00;
    end else begin
      reg_thr  <= next_reg_thr;
      reg_hold <= next_reg_hold;
      rdata    <= next_rdata;
    end
  end

  assign o_rdata  = rdata;
  assign o_enable = reg_thr[DRC_BIT_ENABLE];
  assign thr_db   = DRC_THR_TOP_DB + DRC_THR_STEP_DB * {5'h00, reg_thr[DRC_THR_LSB +: 3]};
  assign o_threshold_db  = thr_db;
  assign o_hysteresis_db = reg_thr[1:0];
  assign hold_code = reg_hold[DRC_HOLD_LSB +: 4];

  always_comb begin
    case (hold_code)
      4'hD:    hold_len = DRC_HOLD_13;
      4'hE:    hold_len = DRC_HOLD_14;
      4'hF:    hold_len = DRC_HOLD_15;
      4'h0:    hold_len = 18'h00000;
      default: hold_len = DRC_HOLD_BASE << (hold_code - 4'h1);
    endcase
  end

  // release point lies the hysteresis further below the threshold
  assign rel_db = {1'b0, thr_db} + {7'h00, reg_thr[1:0]};
  assign over   = i_level_db < thr_db;
  assign under  = {1'b0, i_level_db} > rel_db;

  always_comb begin
    next_state    = state;
    next_hold_cnt = hold_cnt;
    if (!o_enable) begin
      next_state    = DRC_IDLE;
      next_hold_cnt = 18'h00000;
    end else if (i_word_clk) begin
      case (state)
        DRC_IDLE: begin
          if (over) begin
            next_state = DRC_COMPRESS;
          end
        end
        DRC_COMPRESS: begin
          if (under) begin
            if (hold_code == 4'h0) begin
              next_state = DRC_IDLE;
            end else begin
              next_state    = DRC_HOLDING;
              next_hold_cnt = hold_len - 18'h00001;
            end
          end
        end
        DRC_HOLDING: begin
          if (!under) begin
            next_state = DRC_COMPRESS;
          end else if (hold_cnt == 18'h00000) begin
            next_state = DRC_IDLE;
          end else begin
            next_hold_cnt = hold_cnt - 18'h00001;
          end
        end
        default: next_state = DRC_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state    <= DRC_IDLE;
      hold_cnt <= 18'h00000;
    end else begin
      state    <= next_state;
      hold_cnt <= next_hold_cnt;
    end
  end

  assign o_reduce = o_enable && (state != DRC_IDLE);

  a_bypass_off: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !o_enable |-> !o_reduce) else $error("reduce while disabled");
  a_thr_decode: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (reg_thr[4:2] == 3'b111) |-> (o_threshold_db == 8'd24)) else $error("bad threshold");
  a_hyst_decode: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_hysteresis_db == reg_thr[1:0]) else $error("bad hysteresis");
  a_hold_off: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (hold_code == 4'h0) |-> (state != DRC_HOLDING)) else $error("hold while off");
  a_hold_2048: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (hold_code == 4'h7) |-> (hold_len == 18'd2048)) else $error("bad hold 0111");
  a_hold_top: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (hold_code == 4'hF) |-> (hold_len == 18'd163840)) else $error("bad hold 1111");
  a_resv_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (reg_thr[7] == 1'b0) && (reg_thr[5] == 1'b0) && (reg_hold[2:0] == 3'b000))
    else $error("reserved bit set");
  a_attack_start: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_enable && i_word_clk && over && state == DRC_IDLE && !i_wr) |=> o_reduce)
    else $error("no attack");

  // every threshold code checked, so a wrong step size cannot hide between the ends
  a_thr_code0: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (reg_thr[4:2] == 3'b000) |-> (o_threshold_db == 8'h03)) else $error("bad threshold 0");
  a_thr_code1: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (reg_thr[4:2] == 3'b001) |-> (o_threshold_db == 8'h06)) else $error("bad threshold 1");
  a_thr_code2: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (reg_thr[4:2] == 3'b010) |-> (o_threshold_db == 8'h09)) else $error("bad threshold 2");
  a_thr_code3: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (reg_thr[4:2] == 3'b011) |-> (o_threshold_db == 8'h0C)) else $error("bad threshold 3");
  a_thr_code4: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (reg_thr[4:2] == 3'b100) |-> (o_threshold_db == 8'h0F)) else $error("bad threshold 4");
  a_thr_code5: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (reg_thr[4:2] == 3'b101) |-> (o_threshold_db == 8'h12)) else $error("bad threshold 5");
  a_thr_code6: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (reg_thr[4:2] == 3'b110) |-> (o_threshold_db == 8'h15)) else $error("bad threshold 6");

  // hold lengths written out per code; the shifter and the table must agree
  a_hold_code1: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (hold_code == 4'h1) |-> (hold_len == 18'h00020)) else $error("bad hold 1");
  a_hold_code2: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (hold_code == 4'h2) |-> (hold_len == 18'h00040)) else $error("bad hold 2");
  a_hold_code3: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (hold_code == 4'h3) |-> (hold_len == 18'h00080)) else $error("bad hold 3");
  a_hold_code4: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (hold_code == 4'h4) |-> (hold_len == 18'h00100)) else $error("bad hold 4");
  a_hold_code5: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (hold_code == 4'h5) |-> (hold_len == 18'h00200)) else $error("bad hold 5");
  a_hold_code6: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (hold_code == 4'h6) |-> (hold_len == 18'h00400)) else $error("bad hold 6");
  a_hold_code8: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (hold_code == 4'h8) |-> (hold_len == 18'h01000)) else $error("bad hold 8");
  a_hold_code9: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (hold_code == 4'h9) |-> (hold_len == 18'h02000)) else $error("bad hold 9");
  a_hold_code10: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (hold_code == 4'hA) |-> (hold_len == 18'h04000)) else $error("bad hold 10");
  a_hold_code11: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (hold_code == 4'hB) |-> (hold_len == 18'h08000)) else $error("bad hold 11");
  a_hold_code12: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (hold_code == 4'hC) |-> (hold_len == 18'h10000)) else $error("bad hold 12");
  a_hold_code13: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (hold_code == 4'hD) |-> (hold_len == 18'h18000)) else $error("bad hold 13");
  a_hold_code14: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (hold_code == 4'hE) |-> (hold_len == 18'h20000)) else $error("bad hold 14");

  // state only moves on a word clock while enabled and clears to idle when disabled; register writes are left out because
  // they may move the threshold under the level in the same cycle
  a_disable_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !o_enable |=> (state == DRC_IDLE)) else $error("state kept while disabled");
  a_release_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_enable && i_word_clk && under && state == DRC_COMPRESS && hold_code != 4'h0 && !i_wr)
    |=> (state == DRC_HOLDING)) else $error("no hold entry");
  a_hold_count: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_enable && i_word_clk && under && state == DRC_HOLDING && hold_cnt != 18'h00000 && !i_wr)
    |=> (hold_cnt == $past(hold_cnt) - 18'h00001)) else $error("hold not counting");
  a_hold_expire: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_enable && i_word_clk && under && state == DRC_HOLDING && hold_cnt == 18'h00000 && !i_wr)
    |=> (state == DRC_IDLE)) else $error("hold not expiring");
  a_word_only: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_enable && !i_word_clk && !i_wr) |=> $stable(state))
    else $error("state moved without word clock");

  // registers hold without a write; unmapped reads return zero
  a_reg_stable: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !i_wr |=> ($stable(reg_thr) && $stable(reg_hold))) else $error("register drifted");
  a_rdata_unmapped: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_addr != DRC_OFS_THRESHOLD && i_addr != DRC_OFS_HOLD) |=> (o_rdata == 8'h00))
    else $error("unmapped read not zero");
endmodule : drc_compressor

// ==== hw/drc_pkg.sv ====
// Notes on behaviour
// - enable bit low bypasses compression; high compresses playback samples
// - threshold code picks -3 dB down to -24 dB in 3 dB steps
// - hysteresis code 0..3 selects 0..3 dB
// - hold field zero disables the hold function entirely
// - hold counted in word clocks, 32 doubling per code up to 65536
// - codes above 1100 give 98304, 131072 and 163840 word clocks
package drc_pkg;
  localparam logic [6:0] DRC_OFS_THRESHOLD = 7'h44;
  localparam logic [6:0] DRC_OFS_HOLD      = 7'h45;
  localparam int         DRC_BIT_ENABLE    = 6;
  localparam int         DRC_THR_LSB       = 2;
  localparam int         DRC_HOLD_LSB      = 3;
  localparam logic [7:0] DRC_RST_THRESHOLD = 8'h0F;
  localparam logic [7:0] DRC_RST_HOLD      = 8'h38;
  localparam logic [7:0] DRC_MASK_THRESHOLD = 8'h5F;
  localparam logic [7:0] DRC_MASK_HOLD      = 8'h78;
  localparam logic [17:0] DRC_HOLD_BASE    = 18'h00020;
  localparam logic [17:0] DRC_HOLD_13      = 18'h18000;
  localparam logic [17:0] DRC_HOLD_14      = 18'h20000;
  localparam logic [17:0] DRC_HOLD_15      = 18'h28000;
  localparam logic [7:0] DRC_THR_TOP_DB    = 8'h03;
  localparam logic [7:0] DRC_THR_STEP_DB   = 8'h03;
  typedef enum logic [1:0] {
    DRC_IDLE     = 2'b00,
    DRC_COMPRESS = 2'b01,
    DRC_HOLDING  = 2'b11
  } drc_state_t;
endpackage : drc_pkg

// ==== dv/drc_tb.sv ====
`timescale 1ns/100ps
module tb;
  import drc_pkg::*;
  logic       i_clk      = 1'b0;
  logic       i_reset_n  = 1'b0;
  logic       i_wr       = 1'b0;
  logic [6:0] i_addr     = 7'h00;
  logic [7:0] i_wdata    = 8'h00;
  logic       i_word_clk = 1'b0;
  logic [7:0] i_level_db = 8'h28;
  logic [7:0] o_rdata;
  logic [7:0] o_threshold_db;
  logic [1:0] o_hysteresis_db;
  logic       o_enable;
  logic       o_reduce;
  int         err_count  = 0;
  int         tests_run  = 0;
  always #4 i_clk = ~i_clk;
  drc_compressor u_drc_compressor (.i_clk, .i_reset_n, .i_wr, .i_addr, .i_wdata, .o_rdata,
    .i_word_clk, .i_level_db, .o_enable, .o_threshold_db, .o_hysteresis_db, .o_reduce);
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_wr = 1'b1;
    i_addr = a;
    i_wdata = d;
    @(negedge i_clk);
    i_wr = 1'b0;
  endtask : wr
  // two edges waited; read data is registered on the first edge after the address is set
  task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
    @(negedge i_clk);
    i_addr = a;
    repeat (2) @(negedge i_clk);
    chk("rdata", o_rdata, exp);
  endtask : rdc
  task automatic wc(input logic [7:0] lv, input int n);
    repeat (n) begin
      @(negedge i_clk);
      i_word_clk = 1'b1;
      i_level_db = lv;
      @(negedge i_clk);
      i_word_clk = 1'b0;
    end
  endtask : wc
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  initial begin
    repeat (16) @(negedge i_clk);
    i_reset_n = 1'b1;
    rdc(DRC_OFS_THRESHOLD, DRC_RST_THRESHOLD);
    rdc(DRC_OFS_HOLD, DRC_RST_HOLD);
    rdc(7'h10, 8'h00);
    chk("enable", {7'h00, o_enable}, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(DRC_OFS_THRESHOLD, 8'((c << 2) | (c % 4)));
      chk("threshold", o_threshold_db, 8'(3 + 3 * c));
      chk("hysteresis", {6'h00, o_hysteresis_db}, 8'(c % 4));
    end
    // reserved positions carry their reset value only, all writable bits set
    wr(DRC_OFS_THRESHOLD, 8'h5F);
    rdc(DRC_OFS_THRESHOLD, 8'h5F);
    wr(DRC_OFS_HOLD, 8'h78);
    rdc(DRC_OFS_HOLD, 8'h78);
    // enabled, threshold 12, hysteresis 3, hold 32 word clocks
    wr(DRC_OFS_THRESHOLD, 8'h4F);
    wr(DRC_OFS_HOLD, 8'h08);
    wc(8'h05, 1);
    chk("reduce loud", {7'h00, o_reduce}, 8'h01);
    wc(8'h0E, 4);
    chk("reduce in band", {7'h00, o_reduce}, 8'h01);
    wc(8'h14, 30);
    chk("reduce hold", {7'h00, o_reduce}, 8'h01);
    wc(8'h14, 6);
    chk("reduce expired", {7'h00, o_reduce}, 8'h00);
    wr(DRC_OFS_HOLD, 8'h00);
    wc(8'h05, 1);
    wc(8'h14, 2);
    chk("reduce no hold", {7'h00, o_reduce}, 8'h00);
    wc(8'h05, 1);
    wr(DRC_OFS_THRESHOLD, 8'h0F);
    chk("reduce disable", {7'h00, o_reduce}, 8'h00);
    wc(8'h05, 2);
    chk("reduce bypass", {7'h00, o_reduce}, 8'h00);
    finish_test();
  end
endmodule : tb
